/* File: src/epcirq_pkg.sv */
// package: register map, field layout and carrier types of the pin interrupt block
package epcirq_pkg;
    localparam int unsigned NUM_EXT    = 3;
    localparam int unsigned NUM_PC     = 32;
    localparam int unsigned NUM_GRP    = 4;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 8;
    // register offsets
    localparam logic [7:0] PC_CTRL_OFF   = 8'h68;
    localparam logic [7:0] SENSE_OFF     = 8'h69;
    localparam logic [7:0] PC_MASK0_OFF  = 8'h6b;
    localparam logic [7:0] PC_MASK1_OFF  = 8'h6c;
    localparam logic [7:0] PC_MASK2_OFF  = 8'h6d;
    localparam logic [7:0] PC_MASK3_OFF  = 8'h73;
    localparam logic [7:0] EXT_MASK_OFF  = 8'h3d;
    localparam logic [7:0] EXT_FLAG_OFF  = 8'h3c;
    localparam logic [7:0] PC_FLAG_OFF   = 8'h3b;
    localparam logic [7:0] GIE_OFF       = 8'h3f;
    // field positions
    localparam int unsigned GIE_BIT      = 7;
    localparam int unsigned SLEEP_BIT    = 0;
    // reset values
    localparam logic [7:0] REG_RST       = 8'h00;
    // sense codes
    localparam logic [1:0] SENSE_LOW     = 2'h0;
    localparam logic [1:0] SENSE_ANY     = 2'h1;
    localparam logic [1:0] SENSE_FALL    = 2'h2;
    localparam logic [1:0] SENSE_RISE    = 2'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } epcirq_bus_req_t;

    typedef struct packed {
        logic [NUM_EXT-1:0] ext_req;
        logic [NUM_GRP-1:0] grp_req;
    } epcirq_irq_t;
endpackage : epcirq_pkg

/* File: src/epcirq_top.sv */
// module: dedicated and pin-change interrupt detection, flags and register file
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module epcirq_top (
    // clock and reset
    input  wire logic                            CLK_I,
    input  wire logic                            SRST_I,
    // register port
    input  wire logic [epcirq_pkg::ADDR_W-1:0]   ADDR_I,
    input  wire logic [epcirq_pkg::DATA_W-1:0]   WDATA_I,
    input  wire logic                            WR_I,
    input  wire logic                            RD_I,
    output logic      [epcirq_pkg::DATA_W-1:0]   RDATA_O,
    // pins
    input  wire logic [epcirq_pkg::NUM_EXT-1:0]  EXT_IRQ_PIN_I,
    input  wire logic [epcirq_pkg::NUM_PC-1:0]   PIN_CHANGE_INPUT_I,
    // power state and cpu side
    input  wire logic                            SLEEP_I,
    input  wire logic [epcirq_pkg::NUM_EXT-1:0]  EXT_ACK_I,
    input  wire logic [epcirq_pkg::NUM_GRP-1:0]  GRP_ACK_I,
    output logic      [epcirq_pkg::NUM_EXT-1:0]  EXT_IRQ_O,
    output logic      [epcirq_pkg::NUM_GRP-1:0]  PIN_CHANGE_GROUP_IRQ_O,
    output logic                                 WAKE_O
);
    epcirq_pkg::epcirq_bus_req_t bus;
    epcirq_pkg::epcirq_irq_t     irq;
    logic [7:0]  sense_control_reg;
    logic [7:0]  ext_irq_mask_reg;
    logic [7:0]  pin_change_control_reg;
    logic [31:0] pin_change_mask_reg;
    logic        gie_reg;
    logic [2:0]  ext_irq_flag_reg;
    logic [3:0]  pin_change_flag_reg;
    logic [2:0]  ext_s1_reg;
    logic [2:0]  ext_s2_reg;
    logic [2:0]  ext_prev_reg;
    logic [31:0] pc_s1_reg;
    logic [31:0] pc_s2_reg;
    logic [31:0] pc_prev_reg;
    logic [2:0]  ext_buf;
    logic [2:0]  ext_event;
    logic [2:0]  ext_level;
    logic [3:0]  grp_event;
    logic [2:0]  ext_wclr;
    logic [3:0]  pc_wclr;
    logic [7:0]  rdata_next;

    assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

    // pin synchronisers: the async capture stage, read only by the second stage
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ext_s1_reg <= '1;
            ext_s2_reg <= '1;
            pc_s1_reg  <= '0;
            pc_s2_reg  <= '0;
        end else begin
            ext_s1_reg <= EXT_IRQ_PIN_I;
            ext_s2_reg <= ext_s1_reg;
            pc_s1_reg  <= PIN_CHANGE_INPUT_I;
            pc_s2_reg  <= pc_s1_reg;
        end
    end

    // sleep gates dedicated input buffers when disabled; a gated pin reads high
    assign ext_buf = ext_s2_reg | ({3{SLEEP_I}} & ~ext_irq_mask_reg[2:0]);

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ext_prev_reg <= 3'h7;
            pc_prev_reg  <= '0;
        end else begin
            ext_prev_reg <= ext_buf;
            pc_prev_reg  <= pc_s2_reg;
        end
    end

    // sense decode per dedicated input
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ext
            logic [1:0] code;
            assign code = sense_control_reg[2*gi +: 2];
            always_comb begin
                ext_level[gi] = 1'b0;
                ext_event[gi] = 1'b0;
                case (code)
                    epcirq_pkg::SENSE_LOW:  ext_level[gi] = ~ext_buf[gi];
                    epcirq_pkg::SENSE_ANY:  ext_event[gi] = ext_buf[gi] ^ ext_prev_reg[gi];
                    epcirq_pkg::SENSE_FALL: ext_event[gi] = ~ext_buf[gi] & ext_prev_reg[gi];
                    epcirq_pkg::SENSE_RISE: ext_event[gi] = ext_buf[gi] & ~ext_prev_reg[gi];
                    default:                ext_event[gi] = 1'b0;
                endcase
            end
        end
        for (gi = 0; gi < 4; gi++) begin : g_grp
            assign grp_event[gi] = |((pc_s2_reg[8*gi +: 8] ^ pc_prev_reg[8*gi +: 8])
                                     & pin_change_mask_reg[8*gi +: 8]);
        end
    endgenerate

    assign ext_wclr = (bus.wr && bus.addr == epcirq_pkg::EXT_FLAG_OFF) ? bus.wdata[2:0] : 3'h0;
    assign pc_wclr  = (bus.wr && bus.addr == epcirq_pkg::PC_FLAG_OFF) ? bus.wdata[3:0] : 4'h0;

    // configuration registers
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            sense_control_reg      <= epcirq_pkg::REG_RST;
            ext_irq_mask_reg       <= epcirq_pkg::REG_RST;
            pin_change_control_reg <= epcirq_pkg::REG_RST;
            pin_change_mask_reg    <= '0;
            gie_reg                <= 1'b0;
        end else if (bus.wr) begin
            case (bus.addr)
                epcirq_pkg::SENSE_OFF:    sense_control_reg <= {2'h0, bus.wdata[5:0]};
                epcirq_pkg::EXT_MASK_OFF: ext_irq_mask_reg <= {5'h0, bus.wdata[2:0]};
                epcirq_pkg::PC_CTRL_OFF:  pin_change_control_reg <= {4'h0, bus.wdata[3:0]};
                epcirq_pkg::PC_MASK0_OFF: pin_change_mask_reg[7:0]   <= bus.wdata;
                epcirq_pkg::PC_MASK1_OFF: pin_change_mask_reg[15:8]  <= bus.wdata;
                epcirq_pkg::PC_MASK2_OFF: pin_change_mask_reg[23:16] <= bus.wdata;
                epcirq_pkg::PC_MASK3_OFF: pin_change_mask_reg[31:24] <= bus.wdata;
                epcirq_pkg::GIE_OFF:      gie_reg <= bus.wdata[epcirq_pkg::GIE_BIT];
                default: ;
            endcase
        end
    end

    // flags: set wins over ack and write-one clear
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ext_irq_flag_reg    <= '0;
            pin_change_flag_reg <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (sense_control_reg[2*i +: 2] == epcirq_pkg::SENSE_LOW)
                    ext_irq_flag_reg[i] <= 1'b0;
                else if (ext_event[i])
                    ext_irq_flag_reg[i] <= 1'b1;
                else if (EXT_ACK_I[i] || ext_wclr[i])
                    ext_irq_flag_reg[i] <= 1'b0;
            end
            for (int j = 0; j < 4; j++) begin
                if (grp_event[j])
                    pin_change_flag_reg[j] <= 1'b1;
                else if (GRP_ACK_I[j] || pc_wclr[j])
                    pin_change_flag_reg[j] <= 1'b0;
            end
        end
    end

    // requests to the cpu, one line per vector
    always_comb begin
        irq.ext_req = (ext_irq_flag_reg | ext_level) & ext_irq_mask_reg[2:0] & {3{gie_reg}};
        irq.grp_req = pin_change_flag_reg & pin_change_control_reg[3:0] & {4{gie_reg}};
    end
    assign EXT_IRQ_O              = irq.ext_req;
    assign PIN_CHANGE_GROUP_IRQ_O = irq.grp_req;
    assign WAKE_O                 = SLEEP_I & (|irq.ext_req | |irq.grp_req);

    // read port, data in the cycle after the strobe
    always_comb begin
        rdata_next = 8'h00;
        case (bus.addr)
            epcirq_pkg::SENSE_OFF:    rdata_next = {2'h0, sense_control_reg[5:0]};
            epcirq_pkg::EXT_MASK_OFF: rdata_next = ext_irq_mask_reg;
            epcirq_pkg::EXT_FLAG_OFF: rdata_next = {5'h0, ext_irq_flag_reg};
            epcirq_pkg::PC_CTRL_OFF:  rdata_next = {4'h0, pin_change_control_reg[3:0]};
            epcirq_pkg::PC_FLAG_OFF:  rdata_next = {4'h0, pin_change_flag_reg};
            epcirq_pkg::PC_MASK0_OFF: rdata_next = pin_change_mask_reg[7:0];
            epcirq_pkg::PC_MASK1_OFF: rdata_next = pin_change_mask_reg[15:8];
            epcirq_pkg::PC_MASK2_OFF: rdata_next = pin_change_mask_reg[23:16];
            epcirq_pkg::PC_MASK3_OFF: rdata_next = pin_change_mask_reg[31:24];
            epcirq_pkg::GIE_OFF:      rdata_next = {gie_reg, 7'h00};
            default:                  rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            RDATA_O <= '0;
        end else begin
            RDATA_O <= bus.rd ? rdata_next : 8'h00;
        end
    end

    // checks
    sequence s_pc0_toggle;
        (pc_s2_reg[0] != pc_prev_reg[0]) && pin_change_mask_reg[0];
    endsequence

    sequence s_grp1_toggle;
        ((pc_s2_reg[15:8] ^ pc_prev_reg[15:8]) & pin_change_mask_reg[15:8]) != 8'h00;
    endsequence

    sequence s_grp2_toggle;
        ((pc_s2_reg[23:16] ^ pc_prev_reg[23:16]) & pin_change_mask_reg[23:16]) != 8'h00;
    endsequence

    sequence s_grp3_toggle;
        ((pc_s2_reg[31:24] ^ pc_prev_reg[31:24]) & pin_change_mask_reg[31:24]) != 8'h00;
    endsequence

    sequence s_ext0_fall;
        sense_control_reg[1:0] == epcirq_pkg::SENSE_FALL && ext_prev_reg[0] && !ext_buf[0];
    endsequence

    sequence s_ext0_any;
        sense_control_reg[1:0] == epcirq_pkg::SENSE_ANY && (ext_prev_reg[0] != ext_buf[0]);
    endsequence

    sequence s_wake_req;
        SLEEP_I && ((EXT_IRQ_O != 3'h0) || (PIN_CHANGE_GROUP_IRQ_O != 4'h0));
    endsequence

    sequence s_ctrl_read;
        bus.rd && bus.addr == epcirq_pkg::PC_CTRL_OFF;
    endsequence

    sequence s_run_two;
        !$past(SRST_I) && !$past(SRST_I, 2);
    endsequence

    // flag set paths
    AST_GRP0_SET: assert property (@(posedge CLK_I) disable iff (SRST_I)
        s_pc0_toggle |=> pin_change_flag_reg[0])
        else $error("group 0 flag not set after toggle");
    AST_GRP1_SET: assert property (@(posedge CLK_I) disable iff (SRST_I)
        s_grp1_toggle
        |=> pin_change_flag_reg[1])
        else $error("group 1 flag not set after toggle");
    AST_GRP2_SET: assert property (@(posedge CLK_I) disable iff (SRST_I)
        s_grp2_toggle
        |=> pin_change_flag_reg[2])
        else $error("group 2 flag not set after toggle");
    AST_GRP3_SET: assert property (@(posedge CLK_I) disable iff (SRST_I)
        s_grp3_toggle
        |=> pin_change_flag_reg[3])
        else $error("group 3 flag not set after toggle");
    AST_MASK_GATES: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (pin_change_mask_reg[7:0] == 8'h00) && !pin_change_flag_reg[0]
        |=> !pin_change_flag_reg[0])
        else $error("masked group raised flag");
    AST_RISE_SET: assert property (@(posedge CLK_I) disable iff (SRST_I)
        sense_control_reg[1:0] == 2'h3 && !ext_prev_reg[0] ##0 ext_buf[0]
        |=> ext_irq_flag_reg[0])
        else $error("rising edge flag missing");
    AST_FALL_SET: assert property (@(posedge CLK_I) disable iff (SRST_I)
        s_ext0_fall
        |=> ext_irq_flag_reg[0])
        else $error("falling edge flag missing");
    AST_ANY_SET: assert property (@(posedge CLK_I) disable iff (SRST_I)
        s_ext0_any
        |=> ext_irq_flag_reg[0])
        else $error("any edge flag missing");

    // level sensing
    AST_LOW_FLAG_ZERO: assert property (@(posedge CLK_I) disable iff (SRST_I)
        $past(sense_control_reg[1:0] == 2'h0) |-> !ext_irq_flag_reg[0])
        else $error("level mode flag not cleared");
    AST_LOW_REQ: assert property (@(posedge CLK_I) disable iff (SRST_I)
        sense_control_reg[1:0] == 2'h0 && !ext_buf[0] && ext_irq_mask_reg[0] && gie_reg
        |-> EXT_IRQ_O[0])
        else $error("low level request missing");
    AST_EDGE_NO_LEVEL: assert property (@(posedge CLK_I) disable iff (SRST_I)
        sense_control_reg[1:0] != epcirq_pkg::SENSE_LOW
        |-> !ext_level[0])
        else $error("level request in edge mode");
    AST_VANISHED_LEVEL: assert property (@(posedge CLK_I) disable iff (SRST_I)
        sense_control_reg[1:0] == epcirq_pkg::SENSE_LOW && ext_buf[0] && !ext_irq_flag_reg[0]
        |-> !EXT_IRQ_O[0])
        else $error("request after level vanished");

    // clears and their priority
    AST_SET_WINS: assert property (@(posedge CLK_I) disable iff (SRST_I)
        grp_event[1] && GRP_ACK_I[1] |=> pin_change_flag_reg[1])
        else $error("clear beat a new event");
    AST_WCLR_SET_WINS: assert property (@(posedge CLK_I) disable iff (SRST_I)
        grp_event[0] && pc_wclr[0]
        |=> pin_change_flag_reg[0])
        else $error("write clear beat a new event");
    AST_ACK_CLEARS: assert property (@(posedge CLK_I) disable iff (SRST_I)
        GRP_ACK_I[2] && !grp_event[2] |=> !pin_change_flag_reg[2])
        else $error("ack did not clear group flag");
    AST_PC_WCLR: assert property (@(posedge CLK_I) disable iff (SRST_I)
        pc_wclr[0] && !grp_event[0]
        |=> !pin_change_flag_reg[0])
        else $error("write one did not clear group flag");
    AST_EXT_ACK_CLEARS: assert property (@(posedge CLK_I) disable iff (SRST_I)
        EXT_ACK_I[0] && !ext_event[0]
        |=> !ext_irq_flag_reg[0])
        else $error("ack did not clear dedicated flag");
    AST_EXT_WCLR: assert property (@(posedge CLK_I) disable iff (SRST_I)
        ext_wclr[0] && !ext_event[0]
        |=> !ext_irq_flag_reg[0])
        else $error("write one did not clear dedicated flag");

    // request gating
    AST_GIE_GATE: assert property (@(posedge CLK_I) disable iff (SRST_I)
        !gie_reg |-> (EXT_IRQ_O == 3'h0) && (PIN_CHANGE_GROUP_IRQ_O == 4'h0))
        else $error("request without global enable");
    AST_EXT_MASK_GATE: assert property (@(posedge CLK_I) disable iff (SRST_I)
        !ext_irq_mask_reg[0]
        |-> !EXT_IRQ_O[0])
        else $error("request without input enable");
    AST_EXT_REQ_FLAG: assert property (@(posedge CLK_I) disable iff (SRST_I)
        ext_irq_flag_reg[0] && ext_irq_mask_reg[0] && gie_reg
        |-> EXT_IRQ_O[0])
        else $error("enabled dedicated flag not requested");
    AST_GRP_EN: assert property (@(posedge CLK_I) disable iff (SRST_I)
        PIN_CHANGE_GROUP_IRQ_O[3] |-> pin_change_control_reg[3] && pin_change_flag_reg[3])
        else $error("group request without enable");
    AST_GRP_REQ_FLAG: assert property (@(posedge CLK_I) disable iff (SRST_I)
        pin_change_flag_reg[0] && pin_change_control_reg[0] && gie_reg
        |-> PIN_CHANGE_GROUP_IRQ_O[0])
        else $error("enabled group flag not requested");
    AST_GRP_VECTOR_SEP: assert property (@(posedge CLK_I) disable iff (SRST_I)
        PIN_CHANGE_GROUP_IRQ_O[1]
        |-> pin_change_flag_reg[1])
        else $error("group request without its own flag");

    // sleep, wake and pin synchronisers
    AST_WAKE: assert property (@(posedge CLK_I) disable iff (SRST_I)
        s_wake_req
        |-> WAKE_O)
        else $error("no wake on pending request");
    AST_NO_WAKE_AWAKE: assert property (@(posedge CLK_I) disable iff (SRST_I)
        !SLEEP_I
        |-> !WAKE_O)
        else $error("wake while not asleep");
    AST_SLEEP_GATE: assert property (@(posedge CLK_I) disable iff (SRST_I)
        SLEEP_I && !ext_irq_mask_reg[0]
        |-> ext_buf[0])
        else $error("disabled buffer not gated in sleep");
    AST_SLEEP_FLAG: assert property (@(posedge CLK_I) disable iff (SRST_I)
        SLEEP_I && !ext_irq_mask_reg[0] && !ext_prev_reg[0] && sense_control_reg[1:0] == 2'h3
        |=> ext_irq_flag_reg[0])
        else $error("buffer gating did not set flag");
    AST_EXT_SYNC: assert property (@(posedge CLK_I) disable iff (SRST_I)
        s_run_two
        |-> ext_s2_reg == $past(EXT_IRQ_PIN_I, 2))
        else $error("dedicated pin not seen after two stages");
    AST_PC_SYNC: assert property (@(posedge CLK_I) disable iff (SRST_I)
        s_run_two
        |-> pc_s2_reg == $past(PIN_CHANGE_INPUT_I, 2))
        else $error("change pin not seen after two stages");

    // register port
    AST_SENSE_TOP_ZERO: assert property (@(posedge CLK_I) disable iff (SRST_I)
        $past(bus.rd) && $past(bus.addr) == epcirq_pkg::SENSE_OFF |-> RDATA_O[7:6] == 2'h0)
        else $error("sense upper bits nonzero");
    AST_CTRL_TOP_ZERO: assert property (@(posedge CLK_I) disable iff (SRST_I)
        s_ctrl_read
        |=> RDATA_O[7:4] == 4'h0)
        else $error("group control upper bits nonzero");
    AST_RDATA_IDLE: assert property (@(posedge CLK_I) disable iff (SRST_I)
        !$past(bus.rd)
        |-> RDATA_O == 8'h00)
        else $error("read data outside read cycle");
    AST_MASK_RESET: assert property (@(posedge CLK_I) disable iff (SRST_I)
        $past(SRST_I)
        |-> pin_change_mask_reg == 32'h0 && pin_change_control_reg == 8'h00)
        else $error("masks not zero after reset");
endmodule : epcirq_top
`default_nettype wire

/* File: tb/epcirq_cpu_model.sv */
// cpu side model: acknowledges the lowest pending request with a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module epcirq_cpu_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // requests and ack control
    input  wire logic       ack_en_i,
    input  wire logic [2:0] ext_irq_i,
    input  wire logic [3:0] grp_irq_i,
    output logic      [2:0] ext_ack_o,
    output logic      [3:0] grp_ack_o
);
    logic busy;
    assign busy = (ext_ack_o != 3'h0) || (grp_ack_o != 4'h0);
    // one vector entry per pulse, dedicated inputs first, one vector per group
    always_ff @(posedge clk_i) begin
        ext_ack_o <= 3'h0;
        grp_ack_o <= 4'h0;
        if (!rst_i && ack_en_i && !busy) begin
            if (ext_irq_i != 3'h0) begin
                ext_ack_o <= ext_irq_i & (~ext_irq_i + 3'h1);
            end else begin
                grp_ack_o <= grp_irq_i & (~grp_irq_i + 4'h1);
            end
        end
    end
endmodule : epcirq_cpu_model
`default_nettype wire

/* File: tb/external_and_pin_change_irq_test.sv */
// self-checking bench of the pin interrupt block
`timescale 1ns/1ps
`default_nettype none
module external_and_pin_change_irq_test;
    logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, sleep = 1'b0, ack_en = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic [2:0]  ext_pin = 3'h7, ext_ack, ext_irq;
    logic [31:0] pc_pin = 32'h0;
    logic [3:0]  grp_ack, grp_irq;
    logic        wake;
    int          n_fail = 0, n_checks = 0;
    logic [23:0] rows [9] = '{{8'h68, 8'hff, 8'h0f}, {8'h69, 8'hff, 8'h3f}, {8'h6b, 8'hff, 8'hff},
        {8'h6c, 8'hff, 8'hff}, {8'h6d, 8'hff, 8'hff}, {8'h73, 8'hff, 8'hff},
        {8'h3d, 8'hff, 8'h07}, {8'h3f, 8'hff, 8'h80}, {8'h50, 8'hff, 8'h00}};
    logic [7:0]  mask_off [4] = '{8'h6b, 8'h6c, 8'h6d, 8'h73};

    always #2 clk = ~clk;

    epcirq_top epcirq_top_inst (.CLK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .EXT_IRQ_PIN_I(ext_pin),
        .PIN_CHANGE_INPUT_I(pc_pin), .SLEEP_I(sleep), .EXT_ACK_I(ext_ack), .GRP_ACK_I(grp_ack),
        .EXT_IRQ_O(ext_irq), .PIN_CHANGE_GROUP_IRQ_O(grp_irq), .WAKE_O(wake));

    epcirq_cpu_model epcirq_cpu_model_inst (.clk_i(clk), .rst_i(srst), .ack_en_i(ack_en),
        .ext_irq_i(ext_irq), .grp_irq_i(grp_irq), .ext_ack_o(ext_ack), .grp_ack_o(grp_ack));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd_chk

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_n

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude

    initial begin
        #100000;
        n_fail++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        #1 chk({1'b0, ext_irq, grp_irq}, 8'h00);
        foreach (rows[i]) rd_chk(rows[i][23:16], 8'h00);
        foreach (rows[i]) begin
            wr_reg(rows[i][23:16], rows[i][15:8]);
            rd_chk(rows[i][23:16], rows[i][7:0]);
        end
        // sense codes on dedicated input 0, pins held for many cycles
        for (int c = 0; c < 4; c++) begin
            wr_reg(8'h3d, 8'h00);
            wr_reg(8'h69, {6'h00, c[1:0]});
            wr_reg(8'h3c, 8'h07);
            wr_reg(8'h3d, 8'h01);
            @(posedge clk) ext_pin[0] <= 1'b0;
            wait_n(5);
            chk({7'h0, ext_irq[0]}, {7'h0, c != 3});
            if (c == 0) rd_chk(8'h3c, 8'h00);
            wr_reg(8'h3c, 8'h07);
            @(posedge clk) ext_pin[0] <= 1'b1;
            wait_n(5);
            chk({7'h0, ext_irq[0]}, {7'h0, c[0]});
        end
        wr_reg(8'h3f, 8'h00);
        #1 chk({5'h0, ext_irq}, 8'h00);
        rd_chk(8'h3c, 8'h01);
        wr_reg(8'h3f, 8'h80);
        #1 chk({5'h0, ext_irq}, 8'h01);
        ack_en <= 1'b1;
        wait_n(3);
        chk({5'h0, ext_irq}, 8'h00);
        ack_en <= 1'b0;
        wr_reg(8'h3d, 8'h00);
        foreach (mask_off[g]) wr_reg(mask_off[g], 8'h00);
        for (int g = 0; g < 4; g++) begin
            wr_reg(8'h68, 8'h01 << g);
            wr_reg(mask_off[g], 8'h08);
            @(posedge clk) pc_pin[g * 8 + 4] <= 1'b1;
            wait_n(5);
            chk({4'h0, grp_irq}, 8'h00);
            @(posedge clk) pc_pin[g * 8 + 3] <= 1'b1;
            wait_n(5);
            chk({4'h0, grp_irq}, 8'h01 << g);
            rd_chk(8'h3b, 8'h01 << g);
            ack_en <= 1'b1;
            wait_n(3);
            chk({4'h0, grp_irq}, 8'h00);
            rd_chk(8'h3b, 8'h00);
            ack_en <= 1'b0;
            wr_reg(mask_off[g], 8'h00);
        end
        wr_reg(8'h68, 8'h01);
        wr_reg(8'h6b, 8'h08);
        @(posedge clk) sleep <= 1'b1;
        @(posedge clk) pc_pin[3] <= 1'b0;
        wait_n(5);
        chk({7'h0, wake}, 8'h01);
        @(posedge clk) sleep <= 1'b0;
        wait_n(1);
        chk({7'h0, wake}, 8'h00);
        // write-one clear in the very cycle of a new change: the change wins
        @(posedge clk) pc_pin[3] <= 1'b1;
        @(posedge clk);
        wr_reg(8'h3b, 8'h01);
        rd_chk(8'h3b, 8'h01);
        wr_reg(8'h3b, 8'h01);
        rd_chk(8'h3b, 8'h00);
        wait_n(1);
        chk(rdata, 8'h00);
        // sleep gates the disabled buffer high: a rise is seen on input 0
        @(posedge clk) ext_pin[0] <= 1'b0;
        wait_n(4);
        wr_reg(8'h3c, 8'h07);
        @(posedge clk) sleep <= 1'b1;
        wait_n(3);
        rd_chk(8'h3c, 8'h01);
        @(posedge clk) sleep <= 1'b0;
        // reset in mid-run
        @(posedge clk) srst <= 1'b1;
        wait_n(2);
        chk({1'b0, ext_irq, grp_irq}, 8'h00);
        @(posedge clk) srst <= 1'b0;
        foreach (rows[i]) rd_chk(rows[i][23:16], 8'h00);
        rd_chk(8'h3c, 8'h00);
        rd_chk(8'h3b, 8'h00);
        conclude();
    end
endmodule : external_and_pin_change_irq_test
`default_nettype wire
